// File: common/dpu_defines.svh
`ifndef DPU_DEFINES_SVH
`define DPU_DEFINES_SVH

// Special function register addresses seen by the core.
`define DPU_CTRL_ADDR 8'ha7
`define DPU_LOW_ADDR 8'h82
`define DPU_HIGH_ADDR 8'h83
`define DPU_PAGE_ADDR 8'h84

// Field positions inside pointer_control.
`define DPU_SWAP_BIT 6
`define DPU_SMODE_HI 5
`define DPU_SMODE_LO 4
`define DPU_MMODE_HI 3
`define DPU_MMODE_LO 2
`define DPU_SEL_BIT 0

// Reset values.
`define DPU_CTRL_RESET 8'h00
`define DPU_PTR_RESET 24'h000000

`endif

// File: common/dpu_pkg.sv
package dpu_pkg;

    // Post-move adjust mode of one pointer.
    typedef enum logic [1:0] {
        DPU_MODE_HOLD = 2'h0,
        DPU_MODE_INC = 2'h1,
        DPU_MODE_DEC = 2'h2,
        DPU_MODE_FLIP = 2'h3
    } dpu_mode_t;

    // Addressing form of a finished move instruction.
    typedef enum logic [1:0] {
        DPU_MOVE_PTR = 2'h0,
        DPU_MOVE_PC = 2'h1,
        DPU_MOVE_IDX = 2'h2
    } dpu_move_t;

    // One access from the core to the special function register space.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } dpu_sfr_req_t;

    // Stored bits of pointer_control; bits 7 and 1 have no storage.
    typedef struct packed {
        logic auto_swap_enable;
        dpu_mode_t shadow_mode;
        dpu_mode_t main_mode;
        logic pointer_select;
    } dpu_ctrl_t;

endpackage : dpu_pkg

// File: core/dpu_pointer_unit.sv
`include "dpu_defines.svh"

module dpu_pointer_unit (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Special function register access from the core.
    input wire dpu_pkg::dpu_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    // Move instruction completion from the core.
    input wire logic move_done_i,
    input wire dpu_pkg::dpu_move_t move_kind_i,
    // Whole-pointer load and increment instructions.
    input wire logic ptr_load_i,
    input wire logic [23:0] ptr_load_val_i,
    input wire logic ptr_inc_i,
    // Pointer seen by the core for addressing.
    output logic [23:0] active_pointer_o,
    output logic pointer_select_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations.
    dpu_pkg::dpu_ctrl_t ctrl_q; // Stored control bits.
    dpu_pkg::dpu_ctrl_t ctrl_d; // Next control bits.
    logic [7:0] rdata_q; // Registered read data.
    logic [7:0] rdata_d; // Next read data.
    logic [23:0] main_ptr; // Main pointer contents.
    logic [23:0] shadow_ptr; // Shadow pointer contents.
    logic ptr_move; // A move addressed through the pointer.
    logic ctrl_wr; // Software write to pointer_control.
    logic [2:0] byte_hit; // Write decode for low, high, page.
    logic [2:0] main_wr; // Byte writes steered to the main pointer.
    logic [2:0] shadow_wr; // Byte writes steered to the shadow one.
    logic [23:0] view; // Pointer visible in the byte registers.

    ////////////////////////////////////////////////////////////////////
    // Decode. Moves relative to the program counter or through an
    // index register never touch either pointer.
    assign ptr_move = move_done_i &&
        move_kind_i == dpu_pkg::DPU_MOVE_PTR;
    assign ctrl_wr = sfr_req_i.wr && sfr_req_i.addr == `DPU_CTRL_ADDR;
    assign byte_hit[0] = sfr_req_i.wr && sfr_req_i.addr == `DPU_LOW_ADDR;
    assign byte_hit[1] = sfr_req_i.wr && sfr_req_i.addr == `DPU_HIGH_ADDR;
    assign byte_hit[2] = sfr_req_i.wr && sfr_req_i.addr == `DPU_PAGE_ADDR;

    // Byte writes, loads and increments go to the active pointer only.
    assign main_wr = ctrl_q.pointer_select ? 3'h0 : byte_hit;
    assign shadow_wr = ctrl_q.pointer_select ? byte_hit : 3'h0;

    ////////////////////////////////////////////////////////////////////
    // The two pointers. Each adjusts by its own mode field, and only
    // when it is the one that the move used (select before the swap).
    dpu_ptr_reg u_main (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .byte_wr_i(main_wr),
        .wdata_i(sfr_req_i.wdata),
        .load_i(ptr_load_i && !ctrl_q.pointer_select),
        .load_val_i(ptr_load_val_i),
        .inc_i(ptr_inc_i && !ctrl_q.pointer_select),
        .adj_i(ptr_move && !ctrl_q.pointer_select),
        .mode_i(ctrl_q.main_mode),
        .ptr_o(main_ptr)
    );

    dpu_ptr_reg u_shadow (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .byte_wr_i(shadow_wr),
        .wdata_i(sfr_req_i.wdata),
        .load_i(ptr_load_i && ctrl_q.pointer_select),
        .load_val_i(ptr_load_val_i),
        .inc_i(ptr_inc_i && ctrl_q.pointer_select),
        .adj_i(ptr_move && ctrl_q.pointer_select),
        .mode_i(ctrl_q.shadow_mode),
        .ptr_o(shadow_ptr)
    );

    ////////////////////////////////////////////////////////////////////
    // Control register next value. A software write in the same cycle
    // as a swap wins, so that code which sets the select explicitly
    // is never overturned by a move finishing alongside it. Bits 7
    // and 1 are dropped, so an increment of the whole register turns
    // the select over without carrying into the mode fields.
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d.auto_swap_enable = sfr_req_i.wdata[`DPU_SWAP_BIT];
            ctrl_d.shadow_mode = dpu_pkg::dpu_mode_t'(
                sfr_req_i.wdata[`DPU_SMODE_HI:`DPU_SMODE_LO]);
            ctrl_d.main_mode = dpu_pkg::dpu_mode_t'(
                sfr_req_i.wdata[`DPU_MMODE_HI:`DPU_MMODE_LO]);
            ctrl_d.pointer_select = sfr_req_i.wdata[`DPU_SEL_BIT];
        end else if (ptr_move && ctrl_q.auto_swap_enable) begin
            // The adjust above uses the old select; the swap follows.
            ctrl_d.pointer_select = !ctrl_q.pointer_select;
        end
    end

    // Register stage; power-on selects main, no adjust, no swap.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= dpu_pkg::dpu_ctrl_t'(6'h00);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Visible pointer: the byte registers and the addressing path both
    // show the selected pointer. Kept as a mux of two flop banks so the
    // core sees a new selection with no extra cycle.
    assign view = ctrl_q.pointer_select ? shadow_ptr : main_ptr;
    assign active_pointer_o = view;
    assign pointer_select_o = ctrl_q.pointer_select;

    ////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe. Unmapped addresses
    // and idle cycles return zero, which the core may OR with others.
    always_comb begin
        rdata_d = 8'h00;
        if (sfr_req_i.rd) begin
            unique case (sfr_req_i.addr)
                `DPU_CTRL_ADDR: begin
                    // Bits 7 and 1 always read zero.
                    rdata_d = {1'b0, ctrl_q.auto_swap_enable,
                        ctrl_q.shadow_mode, ctrl_q.main_mode,
                        1'b0, ctrl_q.pointer_select};
                end
                `DPU_LOW_ADDR: rdata_d = view[7:0];
                `DPU_HIGH_ADDR: rdata_d = view[15:8];
                `DPU_PAGE_ADDR: rdata_d = view[23:16];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Read data register.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    logic no_sw; // No software write or core load in this cycle.
    assign no_sw = !sfr_req_i.wr && !ptr_load_i && !ptr_inc_i;

    sequence s_main_inc_move;
        ptr_move && no_sw && !ctrl_q.pointer_select &&
        ctrl_q.main_mode == dpu_pkg::DPU_MODE_INC &&
        ctrl_q.auto_swap_enable;
    endsequence

    sequence s_main_bumped_then_shadow;
        main_ptr == 24'($past(main_ptr) + 24'h000001) &&
        ctrl_q.pointer_select && active_pointer_o == shadow_ptr;
    endsequence

    a_main_view: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        sfr_req_i.rd && sfr_req_i.addr == `DPU_LOW_ADDR &&
        !ctrl_q.pointer_select |=> sfr_rdata_o == $past(main_ptr[7:0]))
        else $error("main pointer not visible");
    a_shadow_read: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        sfr_req_i.rd && sfr_req_i.addr == `DPU_PAGE_ADDR &&
        ctrl_q.pointer_select ##1 $stable(shadow_ptr)
        |-> sfr_rdata_o == shadow_ptr[23:16])
        else $error("shadow page byte not read back");
    a_swap_on: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ptr_move && !ctrl_wr && ctrl_q.auto_swap_enable
        |=> ctrl_q.pointer_select != $past(ctrl_q.pointer_select))
        else $error("auto swap missing");
    a_swap_off: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !ctrl_wr && !ctrl_q.auto_swap_enable |=> $stable(pointer_select_o))
        else $error("select changed without swap enable");
    a_mode_store: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ctrl_wr |=> ctrl_q.shadow_mode == $past(sfr_req_i.wdata[5:4]) &&
        ctrl_q.main_mode == $past(sfr_req_i.wdata[3:2]))
        else $error("mode fields not stored");
    a_other_move: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        move_done_i && move_kind_i != dpu_pkg::DPU_MOVE_PTR && no_sw
        |=> $stable(main_ptr) && $stable(shadow_ptr) &&
        $stable(pointer_select_o))
        else $error("non-pointer move changed a pointer");
    a_bit1_zero: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        sfr_req_i.rd && sfr_req_i.addr == `DPU_CTRL_ADDR
        |=> sfr_rdata_o[1] == 1'b0 && sfr_rdata_o[7] == 1'b0)
        else $error("unimplemented bits read nonzero");
    a_inc_active: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        ptr_inc_i && !sfr_req_i.wr && !ptr_load_i && !ptr_move
        |=> active_pointer_o == 24'($past(active_pointer_o) + 24'h000001))
        else $error("increment missed active pointer");
    a_reset_zero: assert property (@(posedge ref_clk_i)
        sys_rst_i ##1 !sys_rst_i |-> ctrl_q == dpu_pkg::dpu_ctrl_t'(6'h00))
        else $error("control not zero after reset");
    a_adjust_then_swap: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        s_main_inc_move |=> s_main_bumped_then_shadow)
        else $error("adjust and swap out of order");

endmodule : dpu_pointer_unit

// File: core/dpu_ptr_reg.sv
`include "dpu_defines.svh"

module dpu_ptr_reg (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Byte writes: bit 0 low, bit 1 high, bit 2 page.
    input wire logic [2:0] byte_wr_i,
    input wire logic [7:0] wdata_i,
    // Whole-pointer load and explicit increment from the core.
    input wire logic load_i,
    input wire logic [23:0] load_val_i,
    input wire logic inc_i,
    // Post-move adjust request and its mode.
    input wire logic adj_i,
    input wire dpu_pkg::dpu_mode_t mode_i,
    // Pointer contents.
    output logic [23:0] ptr_o
);

    logic [23:0] ptr_q; // Stored pointer.
    logic [23:0] ptr_d; // Next pointer value.

    ////////////////////////////////////////////////////////////////////
    // Next value. Software writes win over the adjust, because a core
    // never writes the pointer and finishes a move with it at once.
    always_comb begin
        ptr_d = ptr_q;
        if (|byte_wr_i) begin
            for (int i = 0; i < 3; i++) begin
                if (byte_wr_i[i]) begin
                    ptr_d[i*8 +: 8] = wdata_i;
                end
            end
        end else if (load_i) begin
            ptr_d = load_val_i;
        end else if (inc_i) begin
            ptr_d = ptr_q + 24'h000001;
        end else if (adj_i) begin
            unique case (mode_i)
                dpu_pkg::DPU_MODE_HOLD: ptr_d = ptr_q;
                dpu_pkg::DPU_MODE_INC: begin
                    ptr_d = ptr_q + 24'h000001;
                end
                dpu_pkg::DPU_MODE_DEC: begin
                    ptr_d = ptr_q - 24'h000001;
                end
                dpu_pkg::DPU_MODE_FLIP: begin
                    ptr_d = ptr_q ^ 24'h000001;
                end
            endcase
        end
    end

    // Register stage; the 24-bit sum wraps naturally at its width.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_q <= `DPU_PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    assign ptr_o = ptr_q;

    ////////////////////////////////////////////////////////////////////
    // Checks on the post-move adjust.
    logic quiet; // An adjust with no competing write.
    assign quiet = adj_i && !(|byte_wr_i) && !load_i && !inc_i;

    a_hold_mode: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        quiet && mode_i == dpu_pkg::DPU_MODE_HOLD |=> $stable(ptr_o))
        else $error("pointer moved in hold mode");
    a_inc_mode: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        quiet && mode_i == dpu_pkg::DPU_MODE_INC
        |=> ptr_o == 24'($past(ptr_o) + 24'h000001))
        else $error("post-increment wrong");
    a_dec_mode: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        quiet && mode_i == dpu_pkg::DPU_MODE_DEC
        |=> ptr_o == 24'($past(ptr_o) - 24'h000001))
        else $error("post-decrement wrong");
    a_flip_mode: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        quiet && mode_i == dpu_pkg::DPU_MODE_FLIP
        |=> ptr_o[23:1] == $past(ptr_o[23:1]) && ptr_o[0] != $past(ptr_o[0]))
        else $error("low bit toggle wrong");
    a_wrap_top: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        quiet && mode_i == dpu_pkg::DPU_MODE_INC && ptr_o == 24'hffffff
        |=> ptr_o == 24'h000000)
        else $error("increment did not wrap");

endmodule : dpu_ptr_reg

// File: test/dpu_core_model.sv
////////////////////////////////////////////////////////////////////////////
// Stand-in for the processor core that finishes moves and reaches the
// special function registers of the pointer unit.
////////////////////////////////////////////////////////////////////////////
module dpu_core_model (
    // Clock.
    input wire logic ref_clk_i,
    // Requests toward the pointer unit.
    output dpu_pkg::dpu_sfr_req_t sfr_req_o,
    output logic move_done_o,
    output dpu_pkg::dpu_move_t move_kind_o,
    output logic ptr_load_o,
    output logic [23:0] ptr_load_val_o,
    output logic ptr_inc_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero.
    initial begin
        sfr_req_o = '0;
        move_done_o = 1'b0;
        move_kind_o = dpu_pkg::DPU_MOVE_PC;
        ptr_load_o = 1'b0;
        ptr_load_val_o = 24'h000000;
        ptr_inc_o = 1'b0;
    end

    // Every call drives all lines once at a falling edge, so back to back
    // calls never assign one line twice in a time step.
    task issue(input dpu_pkg::dpu_sfr_req_t req, input logic md,
               input dpu_pkg::dpu_move_t mk, input logic ld,
               input logic [23:0] lv, input logic inc);
        sfr_req_o = req;
        move_done_o = md;
        move_kind_o = mk;
        ptr_load_o = ld;
        ptr_load_val_o = lv;
        ptr_inc_o = inc;
        @(negedge ref_clk_i);
    endtask : issue
endmodule : dpu_core_model

// File: test/dual_data_pointer_unit_test.sv
`include "dpu_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Bench: random and directed core traffic checked against a model.
////////////////////////////////////////////////////////////////////////////
module dual_data_pointer_unit_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    dpu_pkg::dpu_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic move_done;
    dpu_pkg::dpu_move_t move_kind;
    logic ptr_load;
    logic [23:0] ptr_load_val;
    logic ptr_inc;
    logic [23:0] active_pointer;
    logic pointer_select;
    int n_errors = 0;
    int checks = 0;
    // Model of the control register and both pointers.
    int m_ctrl = 0;
    int m_ptr [2] = '{0, 0};

    // Clock of 8 ns.
    always #4 ref_clk_i = ~ref_clk_i;

    dpu_pointer_unit dut (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .sfr_req_i(sfr_req),
        .sfr_rdata_o(sfr_rdata),
        .move_done_i(move_done),
        .move_kind_i(move_kind),
        .ptr_load_i(ptr_load),
        .ptr_load_val_i(ptr_load_val),
        .ptr_inc_i(ptr_inc),
        .active_pointer_o(active_pointer),
        .pointer_select_o(pointer_select)
    );

    dpu_core_model core (
        .ref_clk_i(ref_clk_i),
        .sfr_req_o(sfr_req),
        .move_done_o(move_done),
        .move_kind_o(move_kind),
        .ptr_load_o(ptr_load),
        .ptr_load_val_o(ptr_load_val),
        .ptr_inc_o(ptr_inc)
    );

    // Compare one value; case inequality so unknowns never match.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run.
    task final_report;
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // One core cycle: 0 write, 1 read, 2 move (val is kind), 3 load, 4 inc.
    task op(input int kind, input logic [23:0] val, input logic [7:0] addr);
        dpu_pkg::dpu_sfr_req_t req;
        dpu_pkg::dpu_move_t mk;
        int sel;
        int sh;
        int mode;
        int rexp;
        int ap;
        logic is_byte;
        sel = m_ctrl & 1;
        mode = 4;
        is_byte = addr >= `DPU_LOW_ADDR && addr <= `DPU_PAGE_ADDR;
        sh = (addr - 8'h82) * 8;
        req.addr = addr;
        req.wr = (kind == 0);
        req.rd = (kind == 1);
        req.wdata = (kind == 0) ? val[7:0] : 8'($urandom);
        mk = dpu_pkg::dpu_move_t'(2'($urandom_range(0, 2)));
        if (kind == 2) mk = dpu_pkg::dpu_move_t'(val[1:0]);
        core.issue(req, kind == 2, mk, kind == 3, val, kind == 4);
        rexp = 0;
        // Byte registers only exist at the three pointer addresses.
        if (addr == `DPU_CTRL_ADDR) begin
            rexp = m_ctrl;
        end else if (is_byte) begin
            rexp = (m_ptr[sel] >> sh) & 'hff;
        end
        case (kind)
            0: begin
                if (addr == `DPU_CTRL_ADDR) begin
                    m_ctrl = val[7:0] & 'h7d;
                end else if (is_byte) begin
                    m_ptr[sel] = m_ptr[sel] & ~('hff << sh);
                    m_ptr[sel] = m_ptr[sel] | (val[7:0] << sh);
                end
            end
            1: check(sfr_rdata, rexp);
            2: begin
                // Only moves through the pointer adjust or swap.
                if (val == 0) begin
                    mode = sel ? (m_ctrl >> 4) & 3 : (m_ctrl >> 2) & 3;
                    if (mode == 1) m_ptr[sel] = (m_ptr[sel] + 1) & 'hffffff;
                    if (mode == 2) m_ptr[sel] = (m_ptr[sel] - 1) & 'hffffff;
                    if (mode == 3) m_ptr[sel] = m_ptr[sel] ^ 1;
                    if (m_ctrl & 'h40) m_ctrl = m_ctrl ^ 1;
                end
            end
            3: m_ptr[sel] = val;
            default: m_ptr[sel] = (m_ptr[sel] + 1) & 'hffffff;
        endcase
        // Active pointer after the cycle, filed by the adjust that ran.
        ap = m_ptr[m_ctrl & 1];
        case (mode)
            0: check(active_pointer, ap);
            1: check(active_pointer, ap);
            2: check(active_pointer, ap);
            3: check(active_pointer, ap);
            default: check(active_pointer, ap);
        endcase
        check(pointer_select, m_ctrl & 1);
    endtask : op

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        logic [23:0] v;
        int k;
        void'($urandom(12));
        repeat (6) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        // Power-on value of the control register.
        op(1, 24'h0, `DPU_CTRL_ADDR);
        // Reserved bits 7 and 1 hold nothing.
        op(0, 24'hff, `DPU_CTRL_ADDR);
        // Adding one to the register only flips the select bit.
        repeat (4) begin
            op(1, 24'h0, `DPU_CTRL_ADDR);
            op(0, 24'(m_ctrl + 1), `DPU_CTRL_ADDR);
        end
        // Every mode on both pointers at both wrap boundaries.
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                for (int w = 0; w < 2; w++) begin
                    op(0, 24'((s ? m << 4 : m << 2) | s | (w << 6)),
                       `DPU_CTRL_ADDR);
                    op(3, w ? 24'hffffff : 24'h000000, 8'h00);
                    op(2, 24'h1, 8'h00);
                    op(2, 24'h2, 8'h00);
                    op(2, 24'h0, 8'h00);
                    op(1, 24'h0, `DPU_PAGE_ADDR);
                end
            end
        end
        // Random back-to-back traffic, unmapped addresses included.
        repeat (400) begin
            k = $urandom_range(0, 4);
            a = 8'($urandom_range(0, 3));
            if ($urandom_range(0, 4) == 4) a = 8'($urandom);
            a = (a == 8'h00) ? `DPU_CTRL_ADDR : (a < 8'h04) ? 8'h81 + a : a;
            v = 24'($urandom);
            if (k == 2) v = 24'($urandom_range(0, 2));
            op(k, v, a);
        end
        // A second reset in mid-run clears the control and both pointers.
        sys_rst_i = 1'b1;
        m_ctrl = 0;
        m_ptr = '{0, 0};
        repeat (2) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        op(1, 24'h0, `DPU_CTRL_ADDR);
        op(1, 24'h0, `DPU_PAGE_ADDR);
        final_report();
    end

    // Watchdog: the sequence needs under 700 cycles.
    initial begin
        #16000;
        n_errors++;
        final_report();
    end
endmodule : dual_data_pointer_unit_test
